// File: hw/eear_pkg.sv
`default_nettype none
package eear_pkg;
    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_CONTROL = 8'h2E;
    localparam logic [7:0] IDX_ADDR_HIGH = 8'h2F;
    localparam logic [7:0] IDX_ADDR_LOW = 8'h30;
    localparam logic [7:0] IDX_DATA_HIGH = 8'h31;
    localparam logic [7:0] IDX_DATA_LOW = 8'h32;
    localparam int ADDR_W = 10;

    // ==========================================================
    // field positions
    localparam int BIT_READ_REQ = 0;
    localparam int BIT_WRITE_REQ = 1;
    localparam int BIT_PROG_FLAG = 3;
    localparam int BIT_BURN_MODE = 7;

    // ==========================================================
    // reset values and limits
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] OTP_LAST = 6'h3F;
    localparam logic [10:0] LOOKUP_LAST = 11'h7FF;
    localparam int OTP_WORDS = 64;

    // ==========================================================
    // timing: times as printed, cycle counts derived at 100 MHz
    localparam longint CLK_HZ = 100_000_000;
    localparam longint BURN_TIME_MS = 150;
    localparam longint HOLD_TIME_MS = 65;
    localparam int BURN_CYCLES_DEF = int'(BURN_TIME_MS * CLK_HZ / 1000);
    localparam int HOLD_CYCLES_DEF = int'(HOLD_TIME_MS * CLK_HZ / 1000);

    // ==========================================================
    // engine states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_OTP_READ = 4'b0010,
        ST_OTP_BURN = 4'b0100,
        ST_LOOKUP = 4'b1000
    } eear_state_t;

    // pending request bits as seen in the control register
    typedef struct packed {
        logic writeReq;
        logic readReq;
    } eear_req_t;
endpackage : eear_pkg
`default_nettype wire

// File: hw/eear_top.sv

`timescale 1ns/100ps
`default_nettype none
module eear_top #(
    parameter int BURN_CYCLES = eear_pkg::BURN_CYCLES_DEF,
    parameter int HOLD_CYCLES = eear_pkg::HOLD_CYCLES_DEF
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [eear_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic burnSupply,
    input wire logic supplyNonZero,
    output logic [10:0] programMemoryAddr,
    input wire logic [15:0] programMemoryData,
    output logic port1Bit5Undefined
);
    import eear_pkg::*;

    // ==========================================================
    // parameter checks; a zero count would set the end compare to all ones and
    // stretch a burn or the pin window to 2^32 cycles, so both must be at least one
    if (BURN_CYCLES < 1 || HOLD_CYCLES < 1) begin : g_bad_param
        $error("cycle counts must be at least one");
    end

    // ==========================================================
    // state
    eear_state_t state;
    eear_req_t req;
    logic burnModeSelect;
    logic [2:0] addrHigh;
    logic [7:0] addrLow;
    logic [7:0] dataHigh;
    logic [7:0] dataLow;
    logic progVoltageFlag;
    logic [31:0] burnCount;
    logic [31:0] holdCount;
    logic holdArmed;
    logic lookupWait; // second look-up cycle, memory word now out
    // store cells keep no reset value; content is unknown until burned
    logic [15:0] otpStore [OTP_WORDS];

    // ==========================================================
    // bus decode; the two low address bits are ignored because
    // every register takes a whole aligned word
    wire logic [7:0] regIndex = paddr[ADDR_W-1:2];
    wire logic hitControl = regIndex == IDX_CONTROL;
    wire logic hitAddrHigh = regIndex == IDX_ADDR_HIGH;
    wire logic hitAddrLow = regIndex == IDX_ADDR_LOW;
    wire logic hitDataHigh = regIndex == IDX_DATA_HIGH;
    wire logic hitDataLow = regIndex == IDX_DATA_LOW;
    wire logic hitAny = hitControl | hitAddrHigh | hitAddrLow
                        | hitDataHigh | hitDataLow;
    wire logic setupPhase = psel & ~penable;
    // a write lands only at the access edge that sees pready high
    wire logic writeTaken = psel & penable & pready & pwrite & hitAny;
    wire logic busy = state != ST_IDLE;

    // ==========================================================
    // request decision on a control write while idle; a refused
    // request sets no bit, so a poll reads it as finished at once
    wire logic wantRead = pwdata[BIT_READ_REQ];
    wire logic wantWrite = pwdata[BIT_WRITE_REQ];
    wire logic oneRequest = wantRead ^ wantWrite;
    wire logic otpAddrOk = addrLow[7:6] == 2'b00;
    wire logic ctrlWrite = writeTaken & hitControl & ~busy;
    wire logic startOtpRead = ctrlWrite & oneRequest & wantRead
                              & burnModeSelect & otpAddrOk
                              & supplyNonZero;
    wire logic startOtpBurn = ctrlWrite & oneRequest & wantWrite
                              & burnModeSelect & otpAddrOk
                              & burnSupply;
    wire logic startLookup = ctrlWrite & oneRequest & wantRead
                             & ~burnModeSelect;

    // ==========================================================
    // address arithmetic after completion; saturation keeps the
    // pointer on the last word instead of wrapping to zero
    wire logic [10:0] lookupAddr = {addrHigh, addrLow};
    wire logic [10:0] lookupNext = (lookupAddr == LOOKUP_LAST) ?
                                   lookupAddr : lookupAddr + 11'h001;
    wire logic [5:0] otpIndex = addrLow[5:0];
    wire logic [7:0] otpNext = (otpIndex == OTP_LAST) ? addrLow
                               : addrLow + 8'h01;
    wire logic burnDone = state == ST_OTP_BURN
                          && burnCount == 32'(BURN_CYCLES - 1);

    // ==========================================================
    // look-up timing: the memory address leaves a register and the
    // memory answers a cycle later, so back-to-back bus transfers
    // would catch a stale word; the word is taken on the second
    // cycle of the look-up state instead
    wire logic lookupCapture = (state == ST_LOOKUP) && lookupWait;

    // ==========================================================
    // read mux, other bits read as zero; reading has no side
    // effect, so polling the control register is always safe
    logic [7:0] readByte;
    always_comb begin
        readByte = RST_BYTE;
        if (hitControl) begin
            readByte[BIT_PROG_FLAG] = progVoltageFlag;
            readByte[BIT_WRITE_REQ] = req.writeReq;
            readByte[BIT_READ_REQ] = req.readReq;
        end else if (hitAddrHigh) begin
            readByte = {burnModeSelect, 4'h0, addrHigh};
        end else if (hitAddrLow) begin
            readByte = addrLow;
        end else if (hitDataHigh) begin
            readByte = dataHigh;
        end else if (hitDataLow) begin
            readByte = dataLow;
        end
    end

    // ==========================================================
    // apb answer: zero wait, data and error prepared in setup
    // trade: one register per output buys a clean timing path
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setupPhase) begin
                prdata <= {24'h00_0000, readByte};
                pslverr <= ~hitAny; // unmapped: error, no effect
            end
        end
    end

    // ==========================================================
    // engine state machine; request bits are set only while idle
    // and cleared only here, so a set and a clear never meet
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            req <= '0;
            burnCount <= 32'h0000_0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    burnCount <= 32'h0000_0000;
                    if (startOtpRead) begin
                        state <= ST_OTP_READ;
                        req.readReq <= 1'b1;
                    end else if (startOtpBurn) begin
                        state <= ST_OTP_BURN;
                        req.writeReq <= 1'b1;
                    end else if (startLookup) begin
                        state <= ST_LOOKUP;
                        req.readReq <= 1'b1;
                    end
                end
                ST_OTP_BURN: begin
                    burnCount <= burnCount + 32'h0000_0001;
                    if (burnDone) begin
                        state <= ST_IDLE;
                        req.writeReq <= 1'b0;
                    end
                end
                ST_OTP_READ: begin
                    state <= ST_IDLE;
                    req.readReq <= 1'b0;
                end
                ST_LOOKUP: begin
                    // the bit stays up until the word is captured
                    if (lookupWait) begin
                        state <= ST_IDLE;
                        req.readReq <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    req <= '0;
                end
            endcase
        end
    end

    // ==========================================================
    // address and data registers; software writes only while idle
    // engine updates come first; bus writes are refused while busy
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            burnModeSelect <= 1'b0;
            addrHigh <= 3'h0;
            addrLow <= RST_BYTE;
            dataHigh <= RST_BYTE;
            dataLow <= RST_BYTE;
        end else if (state == ST_OTP_READ) begin
            {dataHigh, dataLow} <= otpStore[otpIndex];
            addrLow <= otpNext;
        end else if (lookupCapture) begin
            dataHigh <= programMemoryData[15:8];
            dataLow <= programMemoryData[7:0];
            {addrHigh, addrLow} <= lookupNext;
        end else if (burnDone) begin
            addrLow <= otpNext;
        end else if (writeTaken && !busy) begin
            if (hitAddrHigh) begin
                burnModeSelect <= pwdata[BIT_BURN_MODE];
                addrHigh <= pwdata[2:0];
            end
            if (hitAddrLow) begin
                addrLow <= pwdata[7:0];
            end
            if (hitDataHigh) begin
                dataHigh <= pwdata[7:0];
            end
            if (hitDataLow) begin
                dataLow <= pwdata[7:0];
            end
        end
    end

    // ==========================================================
    // one-time store: a burn can only clear bits, so ones are unused
    // a burn with all ones leaves the word as it was
    always_ff @(posedge core_clk) begin
        if (burnDone) begin
            otpStore[otpIndex] <= otpStore[otpIndex]
                                  & {dataHigh, dataLow};
        end
    end

    // ==========================================================
    // look-up wait flag: high for the second cycle of a look-up,
    // once the program memory has the word out
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lookupWait <= 1'b0;
        end else begin
            lookupWait <= (state == ST_LOOKUP) && !lookupWait;
        end
    end

    // ==========================================================
    // supply flag and look-up address are registered copies
    // one register of lag: a poll sees the pin a cycle late, which
    // is harmless because software checks it well before a burn
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            progVoltageFlag <= 1'b0;
            programMemoryAddr <= 11'h000;
        end else begin
            progVoltageFlag <= burnSupply;
            programMemoryAddr <= lookupAddr;
        end
    end

    // ==========================================================
    // port1 bit5 undefined window after reset with supply high;
    // the supply level is caught on the first edge after release
    // the window is counted in clock cycles, so its length in time
    // scales with the core clock
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            holdArmed <= 1'b1;
            holdCount <= 32'h0000_0000;
            port1Bit5Undefined <= 1'b0;
        end else if (holdArmed) begin
            holdArmed <= 1'b0;
            port1Bit5Undefined <= burnSupply;
        end else if (port1Bit5Undefined) begin
            holdCount <= holdCount + 32'h0000_0001;
            if (holdCount == 32'(HOLD_CYCLES - 1)) begin
                port1Bit5Undefined <= 1'b0;
            end
        end
    end
endmodule : eear_top
`default_nettype wire

// File: tb/eear_props.sv
`timescale 1ns/100ps
`default_nettype none
module eear_props #(
    parameter int BURN_CYCLES = 20,
    parameter int HOLD_CYCLES = 10
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [eear_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic burnSupply,
    input wire logic port1Bit5Undefined
);
    import eear_pkg::*;

    // bus decode; a single clock domain, so one default clocking
    wire logic acc = psel && penable;
    wire logic [7:0] idx = paddr[9:2];
    wire logic mapped = idx >= IDX_CONTROL && idx <= IDX_DATA_LOW;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence setupPh;
        psel && !penable;
    endsequence
    sequence ctrlRead;
        acc && !pwrite && idx == IDX_CONTROL;
    endsequence
    sequence holdRun;
        port1Bit5Undefined [*8];
    endsequence
    // the flag lags the pin by one register and prdata by another, so two samples back
    zero_wait_a: assert property (setupPh |=> pready)
        else $error("ready missing in access phase");
    upper_zero_a: assert property (prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    unmapped_err_a: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access without error");
    mapped_ok_a: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access flagged as error");
    err_data_a: assert property (acc && pslverr |-> prdata == 32'h0000_0000)
        else $error("error answer with data");
    flag_mirror_a: assert property (ctrlRead |-> prdata[3] == $past(burnSupply, 2))
        else $error("voltage flag differs from pin");
    hold_start_a: assert property ($rose(port1Bit5Undefined) |-> $past(burnSupply))
        else $error("pin window without supply");
    hold_len_a: assert property ($rose(port1Bit5Undefined) |-> holdRun)
        else $error("pin window too short");
    // cycles the pin window has been open, for the exact length
    logic [31:0] holdLen;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            holdLen <= 32'h0000_0000;
        end else if (port1Bit5Undefined) begin
            holdLen <= holdLen + 32'h0000_0001;
        end else begin
            holdLen <= 32'h0000_0000;
        end
    end
    hold_max_a: assert property (holdLen <= 32'(HOLD_CYCLES))
        else $error("pin window too long");
    hold_end_a: assert property (
        $fell(port1Bit5Undefined) |-> holdLen == 32'(HOLD_CYCLES))
        else $error("pin window length wrong");
endmodule : eear_props
bind eear_top eear_props #(
    .BURN_CYCLES(BURN_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)
) props (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .burnSupply(burnSupply),
    .port1Bit5Undefined(port1Bit5Undefined)
);
`default_nettype wire

// File: tb/eear_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module eear_top_test;
    import eear_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, burnSupply = 1'b1, supplyNonZero = 1'b1;
    logic [ADDR_W-1:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [15:0] programMemoryData = 16'h0000;
    logic [10:0] programMemoryAddr;
    logic pready, pslverr, port1Bit5Undefined;
    logic [7:0] al[4] = '{8'h40, 8'h05, 8'h05, 8'h05};
    logic [7:0] rq[4] = '{8'h01, 8'h03, 8'h02, 8'h01};
    logic [3:0] bs = 4'b1011, sn = 4'b0111;
    int numErrors = 0, nTests = 0, cyc = 0, t0;
    always #5 core_clk = ~core_clk; // taken as the accurate oscillator
    // synchronous program memory: word is a pattern of its address
    always @(posedge core_clk) programMemoryData <= {5'h15, programMemoryAddr};
    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            numErrors++;
            final_report();
        end
    end
    eear_top #(.BURN_CYCLES(20), .HOLD_CYCLES(10)) DUT (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .burnSupply(burnSupply),
        .supplyNonZero(supplyNonZero), .programMemoryAddr(programMemoryAddr),
        .programMemoryData(programMemoryData),
        .port1Bit5Undefined(port1Bit5Undefined)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            numErrors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one transfer; an idle cycle after it keeps drivers single per step
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (!pready) @(posedge core_clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask : rdc
    task automatic idle();
        do apb(1'b0, IDX_CONTROL, 8'h00);
        while (rd[1:0] !== 2'b00);
    endtask : idle
    task automatic final_report();
        $display("mismatches %0d of %0d checks", numErrors, nTests);
        if (numErrors == 0 && nTests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    initial begin
        // the converter lies outside this block; nothing to pause
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        check(port1Bit5Undefined, 1'b1);
        rdc(IDX_CONTROL, 32'h0000_0008);
        rdc(IDX_ADDR_HIGH, 32'h0000_0000);
        repeat (10) @(posedge core_clk);
        check(port1Bit5Undefined, 1'b0);
        // look-up mode: write refused, reads step and stop at the top
        wr(IDX_ADDR_HIGH, 8'h07);
        wr(IDX_ADDR_LOW, 8'hFE);
        wr(IDX_CONTROL, 8'h02);
        rdc(IDX_CONTROL, 32'h0000_0008);
        for (int i = 0; i < 2; i++) begin
            wr(IDX_CONTROL, 8'h01);
            idle();
            rdc(IDX_DATA_HIGH, 32'h0000_00AF);
            rdc(IDX_DATA_LOW, 32'h0000_00FE + i);
            rdc(IDX_ADDR_LOW, 32'h0000_00FF);
            rdc(IDX_ADDR_HIGH, 32'h0000_0007);
        end
        check(programMemoryAddr, 32'h0000_07FF);
        // burn mode refusals must leave address and data alone
        wr(IDX_ADDR_HIGH, 8'h80);
        wr(IDX_DATA_LOW, 8'h55);
        for (int i = 0; i < 4; i++) begin
            burnSupply <= bs[i];
            supplyNonZero <= sn[i];
            wr(IDX_ADDR_LOW, al[i]);
            wr(IDX_CONTROL, rq[i]);
            rdc(IDX_ADDR_LOW, {24'h00_0000, al[i]});
            rdc(IDX_DATA_LOW, 32'h0000_0055);
            rdc(IDX_CONTROL, {28'h000_0000, bs[i], 3'b000});
        end
        // burn zeros: unburned cells are unknown, zeros give a known word
        supplyNonZero <= 1'b1;
        rdc(IDX_CONTROL, 32'h0000_0008);
        wr(IDX_DATA_HIGH, 8'h00);
        wr(IDX_DATA_LOW, 8'h00);
        for (int i = 0; i < 2; i++) begin
            wr(IDX_ADDR_LOW, i ? 8'h05 : 8'h3F);
            t0 = cyc;
            wr(IDX_CONTROL, 8'h02);
            rdc(IDX_CONTROL, 32'h0000_000A);
            wr(IDX_ADDR_LOW, 8'h10);
            idle();
            check((cyc - t0) inside {[20:34]}, 1'b1);
            rdc(IDX_ADDR_LOW, i ? 32'h0000_0006 : 32'h0000_003F);
        end
        burnSupply <= 1'b0; // a read needs only a live pin
        wr(IDX_DATA_HIGH, 8'hAA);
        wr(IDX_ADDR_LOW, 8'h05);
        wr(IDX_CONTROL, 8'h01);
        idle();
        rdc(IDX_DATA_HIGH, 32'h0000_0000);
        rdc(IDX_DATA_LOW, 32'h0000_0000);
        rdc(IDX_ADDR_LOW, 32'h0000_0006);
        rdc(8'h33, 32'h0000_0000);
        check(pslverr, 1'b1);
        final_report();
    end
endmodule : eear_top_test
`default_nettype wire
